// file: design/hs_pkg.sv
// Package: register map, fields, reset values and states of the homing sequencer
`default_nettype none
package hs_pkg;
	// ==========================================
	// Register byte offsets
	localparam logic [7:0] HS_OFF_CTRL = 8'h00;
	localparam logic [7:0] HS_OFF_METHOD = 8'h04;
	localparam logic [7:0] HS_OFF_STATUS = 8'h08;
	localparam logic [7:0] HS_OFF_IRQ_STAT = 8'h0C;
	localparam logic [7:0] HS_OFF_IRQ_MASK = 8'h10;
	// ==========================================
	// Field positions
	localparam int HS_CTRL_TDS = 0;
	localparam int HS_CTRL_REFLECT = 1;
	localparam int HS_CTRL_START = 4;
	localparam int HS_ST_TARGET = 10;
	localparam int HS_ST_ATTAINED = 12;
	localparam int HS_ST_ALARM = 13;
	localparam int HS_ST_BUSY = 14;
	localparam int HS_IRQ_ATTAINED = 0;
	localparam int HS_IRQ_ALARM = 1;
	// ==========================================
	// Reset values
	localparam logic [2:0] HS_CTRL_RST = 3'h0;
	localparam logic [7:0] HS_METHOD_RST = 8'h00;
	localparam logic [1:0] HS_IRQ_MASK_RST = 2'h0;
	// ==========================================
	// Sequencer states
	typedef enum logic [2:0] {
		HS_IDLE = 3'b000,
		HS_BACKOFF = 3'b001,
		HS_SEARCH = 3'b010,
		HS_REVERSE = 3'b011,
		HS_CREEP = 3'b100,
		HS_STOP = 3'b101,
		HS_DONE = 3'b110,
		HS_FAULT = 3'b111
	} hs_state_t;
	// Decoded homing method
	typedef struct packed {
		logic valid;
		logic curpos;
		logic index;
		logic limit;
		logic dog;
		logic zpulse;
		logic rev_ok;
		logic fwd;
	} hs_minfo_t;
endpackage
`default_nettype wire

// file: design/hs_sequencer.sv
// Homing sequencer with APB register file and interrupt
// How it works
// - Methods 1/2, 17/18, 33/34 and -1/-33 each run as the partner with the search direction turned round.
// - Index-only homing stops the motor and raises the alarm when a stroke end is met.
// - Current-position homing is taken and finished even with the servo off.
// - The travel direction selection at 1 reverses the search direction, at 0 keeps it.
// - The travel direction selection acts on homing only while polarity reflect is 1.
// - Dog homing started on the dog first backs off the dog, then homes normally.
// - Reversal at a stroke end is caused only by the stroke end inputs, no soft limit.
// - Index-only homing moves at creep speed from the start and takes the first index.
// - Methods 17 to 30 move like 1 to 14 but home on the dog or stroke end edge.
// - Current-position homing takes the present position as home without motion.
//
// Local design decisions: the APB register port and the register offsets.
`default_nettype none
module hs_sequencer
	import hs_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic index_pulse_in,
	input wire logic prox_dog_in,
	input wire logic fwd_stroke_end_in,
	input wire logic rev_stroke_end_in,
	input wire logic servo_on,
	input wire logic motor_stopped,
	output logic motor_run,
	output logic motor_fwd,
	output logic motor_creep,
	output logic home_latch,
	output logic homing_attained,
	output logic target_reached,
	output logic homing_incomplete_alarm,
	output logic homing_busy,
	output logic irq
);

	// ==========================================
	// Method decode
	function automatic hs_minfo_t hs_decode(input logic signed [7:0] m);
		hs_minfo_t r;
		logic signed [7:0] b;
		r = '0;
		b = (m >= 8'sd17 && m <= 8'sd30) ? m - 8'sd16 : m;
		r.zpulse = !(m >= 8'sd17 && m <= 8'sd30);
		if (b == 8'sd1 || b == 8'sd2) begin
			r.valid = 1'b1;
			r.limit = 1'b1;
			r.fwd = (b == 8'sd2);
		end else if (b >= 8'sd3 && b <= 8'sd14) begin
			r.valid = 1'b1;
			r.dog = 1'b1;
			r.rev_ok = (b >= 8'sd7);
			r.fwd = (b <= 8'sd4) || (b >= 8'sd7 && b <= 8'sd10);
		end else if (m == 8'sd33 || m == 8'sd34) begin
			r.valid = 1'b1;
			r.index = 1'b1;
			r.fwd = (m == 8'sd34);
		end else if (m == 8'sd35 || m == 8'sd37) begin
			r.valid = 1'b1;
			r.curpos = 1'b1;
		end else if (m == -8'sd1 || m == -8'sd33) begin
			r.valid = 1'b1;
			r.dog = 1'b1;
			r.zpulse = 1'b1;
			r.rev_ok = 1'b1;
			r.fwd = (m == -8'sd1);
		end
		if (b == 8'sd1 || b == 8'sd2) begin
			r.zpulse = !(m >= 8'sd17 && m <= 8'sd30);
		end
		return r;
	endfunction

	// ==========================================
	// Pin synchronisers
	logic [3:0] pin_s1_r;
	logic [3:0] pin_s2_r;
	logic index_d_r;
	logic index_s;
	logic dog_s;
	logic fend_s;
	logic rend_s;
	logic index_rise;

	// Two flops per pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1_r <= 4'h0;
			pin_s2_r <= 4'h0;
			index_d_r <= 1'b0;
		end else begin
			pin_s1_r <= {rev_stroke_end_in, fwd_stroke_end_in, prox_dog_in, index_pulse_in};
			pin_s2_r <= pin_s1_r;
			index_d_r <= pin_s2_r[0];
		end
	end

	assign index_s = pin_s2_r[0];
	assign dog_s = pin_s2_r[1];
	assign fend_s = pin_s2_r[2];
	assign rend_s = pin_s2_r[3];
	assign index_rise = index_s && !index_d_r;

	// ==========================================
	// Register file
	logic [2:0] ctrl_r;
	logic [7:0] method_r;
	logic [1:0] irq_stat_r;
	logic [1:0] irq_mask_r;
	logic start_d_r;
	logic wr_en;
	logic rd_en;
	logic addr_ok;
	logic start_rise;
	logic start_bit;
	logic attained_ev;
	logic alarm_ev;

	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign addr_ok = (paddr == HS_OFF_CTRL) || (paddr == HS_OFF_METHOD) ||
		(paddr == HS_OFF_STATUS) || (paddr == HS_OFF_IRQ_STAT) || (paddr == HS_OFF_IRQ_MASK);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	assign start_bit = ctrl_r[2];

	// Control, method and mask writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= HS_CTRL_RST;
			method_r <= HS_METHOD_RST;
			irq_mask_r <= HS_IRQ_MASK_RST;
		end else if (wr_en) begin
			if (paddr == HS_OFF_CTRL) begin
				ctrl_r <= {pwdata[HS_CTRL_START], pwdata[HS_CTRL_REFLECT], pwdata[HS_CTRL_TDS]};
			end
			if (paddr == HS_OFF_METHOD) begin
				method_r <= pwdata[7:0];
			end
			if (paddr == HS_OFF_IRQ_MASK) begin
				irq_mask_r <= pwdata[1:0];
			end
		end
	end

	// Start edge detect
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_d_r <= 1'b0;
		end else begin
			start_d_r <= start_bit;
		end
	end
	assign start_rise = start_bit && !start_d_r;

	// Sticky events, set wins over write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_r <= 2'h0;
		end else begin
			irq_stat_r <= (irq_stat_r & ~((wr_en && paddr == HS_OFF_IRQ_STAT) ?
				pwdata[1:0] : 2'h0)) | {alarm_ev, attained_ev};
		end
	end

	// Level interrupt
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_r & irq_mask_r);
		end
	end

	// ==========================================
	// Sequencer
	hs_state_t state_r;
	hs_state_t state_nxt;
	hs_minfo_t info_r;
	hs_minfo_t info_now;
	logic dir_r;
	logic dir_nxt;
	logic start_dir;
	logic end_ahead;
	logic end_behind;

	assign info_now = hs_decode(method_r);
	// Selection applied only when reflection is on
	assign start_dir = info_now.fwd ^ (ctrl_r[0] && ctrl_r[1]);
	// Stroke end inputs only, soft limits play no part
	assign end_ahead = dir_r ? fend_s : rend_s;
	assign end_behind = dir_r ? rend_s : fend_s;

	// Next state and direction
	always_comb begin
		state_nxt = state_r;
		dir_nxt = dir_r;
		unique case (state_r)
			HS_IDLE, HS_DONE, HS_FAULT: begin
				if (start_rise) begin
					dir_nxt = start_dir;
					if (!info_now.valid) begin
						state_nxt = HS_FAULT;
					end else if (info_now.curpos) begin
						state_nxt = HS_DONE;
					end else if (!servo_on) begin
						state_nxt = HS_FAULT;
					end else if (info_now.index) begin
						state_nxt = HS_CREEP;
					end else if (info_now.dog && dog_s) begin
						state_nxt = HS_BACKOFF;
					end else begin
						state_nxt = HS_SEARCH;
					end
				end
			end
			HS_BACKOFF: begin
				if (!dog_s) begin
					state_nxt = HS_SEARCH;
				end else if (end_behind) begin
					state_nxt = HS_FAULT;
				end
			end
			HS_SEARCH: begin
				if (info_r.dog && dog_s) begin
					state_nxt = info_r.zpulse ? HS_CREEP : HS_STOP;
				end else if (end_ahead) begin
					if (info_r.limit) begin
						state_nxt = info_r.zpulse ? HS_CREEP : HS_STOP;
						dir_nxt = info_r.zpulse ? !dir_r : dir_r;
					end else if (info_r.rev_ok) begin
						state_nxt = HS_REVERSE;
						dir_nxt = !dir_r;
					end else begin
						state_nxt = HS_FAULT;
					end
				end
			end
			HS_REVERSE: begin
				if (!dog_s && end_ahead) begin
					state_nxt = HS_FAULT;
				end else if (dog_s) begin
					state_nxt = HS_BACKOFF;
					dir_nxt = !dir_r;
				end
			end
			HS_CREEP: begin
				if (index_rise) begin
					state_nxt = HS_STOP;
				end else if (end_ahead) begin
					state_nxt = HS_FAULT;
				end
			end
			HS_STOP: begin
				if (motor_stopped) begin
					state_nxt = HS_DONE;
				end
			end
		endcase
		if (!start_bit && state_r != HS_IDLE && state_r != HS_DONE && state_r != HS_FAULT) begin
			state_nxt = HS_IDLE;
		end
	end

	// State, direction and method latch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= HS_IDLE;
			dir_r <= 1'b0;
			info_r <= '0;
		end else begin
			state_r <= state_nxt;
			dir_r <= dir_nxt;
			if (start_rise) begin
				info_r <= info_now;
			end
		end
	end

	assign attained_ev = (state_nxt == HS_DONE) && (state_r != HS_DONE || start_rise);
	assign alarm_ev = (state_nxt == HS_FAULT) && (state_r != HS_FAULT || start_rise);

	// Motor command and status outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			motor_run <= 1'b0;
			motor_fwd <= 1'b0;
			motor_creep <= 1'b0;
			home_latch <= 1'b0;
			homing_attained <= 1'b0;
			target_reached <= 1'b0;
			homing_incomplete_alarm <= 1'b0;
			homing_busy <= 1'b0;
		end else begin
			motor_run <= (state_nxt == HS_BACKOFF) || (state_nxt == HS_SEARCH) ||
				(state_nxt == HS_REVERSE) || (state_nxt == HS_CREEP);
			// Back-off runs opposite to the homing direction
			motor_fwd <= (state_nxt == HS_BACKOFF) ? !dir_nxt : dir_nxt;
			motor_creep <= (state_nxt == HS_CREEP) || (state_nxt == HS_BACKOFF);
			// Home taken at the transition into stop, or at once for current position
			home_latch <= ((state_nxt == HS_STOP) && (state_r != HS_STOP)) ||
				(attained_ev && state_r != HS_STOP);
			homing_attained <= (state_nxt == HS_DONE);
			target_reached <= (state_nxt == HS_DONE) || (state_nxt == HS_FAULT) ||
				(state_nxt == HS_IDLE);
			homing_incomplete_alarm <= (state_nxt == HS_FAULT);
			homing_busy <= (state_nxt != HS_IDLE) && (state_nxt != HS_DONE) &&
				(state_nxt != HS_FAULT);
		end
	end

	// ==========================================
	// Read mux
	always_comb begin
		prdata = 32'h0000_0000;
		if (rd_en) begin
			unique case (paddr)
				HS_OFF_CTRL: begin
					prdata[HS_CTRL_TDS] = ctrl_r[0];
					prdata[HS_CTRL_REFLECT] = ctrl_r[1];
					prdata[HS_CTRL_START] = ctrl_r[2];
				end
				HS_OFF_METHOD: prdata[7:0] = method_r;
				HS_OFF_STATUS: begin
					prdata[2:0] = state_r;
					prdata[HS_ST_TARGET] = target_reached;
					prdata[HS_ST_ATTAINED] = homing_attained;
					prdata[HS_ST_ALARM] = homing_incomplete_alarm;
					prdata[HS_ST_BUSY] = homing_busy;
				end
				HS_OFF_IRQ_STAT: prdata[1:0] = irq_stat_r;
				HS_OFF_IRQ_MASK: prdata[1:0] = irq_mask_r;
				default: prdata = 32'h0000_0000;
			endcase
		end
	end

endmodule
`default_nettype wire

// file: verif/hs_axis_model.sv
// Model: axis with encoder index, proximity dog and stroke ends
`default_nettype none
module hs_axis_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic motor_run,
	input wire logic motor_fwd,
	input wire logic motor_creep,
	input wire logic load,
	input wire logic signed [15:0] load_pos,
	output logic index_pulse_in,
	output logic prox_dog_in,
	output logic fwd_stroke_end_in,
	output logic rev_stroke_end_in,
	output logic motor_stopped,
	output logic signed [15:0] pos
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] div;
	// Position; creep takes one step in four cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos <= 16'sh0000;
			div <= 2'h0;
		end else if (load) begin
			pos <= load_pos;
		end else if (motor_run) begin
			div <= div + 2'h1;
			if (!motor_creep || div == 2'h0)
				pos <= motor_fwd ? pos + 16'sh0001 : pos - 16'sh0001;
		end
	end
	// Speed reaches zero one cycle after run drops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			motor_stopped <= 1'b1;
		else
			motor_stopped <= !motor_run;
	end
	// Index each 16 steps, dog 42..54, stroke ends at +-100
	assign index_pulse_in = motor_run && pos[3:0] == 4'h8;
	assign prox_dog_in = pos >= 16'sd42 && pos <= 16'sd54;
	assign fwd_stroke_end_in = pos >= 16'sd100;
	assign rev_stroke_end_in = pos <= -16'sd100;
endmodule
`default_nettype wire

// file: verif/hs_sequencer_assertions.sv
// Checker: port assertions of the homing sequencer
`default_nettype none
module hs_sequencer_assertions
	import hs_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic motor_run,
	input wire logic home_latch,
	input wire logic homing_attained,
	input wire logic target_reached,
	input wire logic homing_incomplete_alarm,
	input wire logic homing_busy
);
	// ==========================================
	// Access decode
	wire logic acc = psel && penable;
	wire logic hit = paddr inside {HS_OFF_CTRL, HS_OFF_METHOD, HS_OFF_STATUS,
		HS_OFF_IRQ_STAT, HS_OFF_IRQ_MASK};
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ==========================================
	// Bus answers
	property p_rdy;
		pready;
	endproperty
	a_rdy: assert property (p_rdy) else $error("pready low");
	property p_err;
		acc && !hit |-> pslverr && prdata == 32'h0;
	endproperty
	a_err: assert property (p_err) else $error("unmapped access not refused");
	property p_ok;
		acc && hit |-> !pslverr;
	endproperty
	a_ok: assert property (p_ok) else $error("mapped access refused");
	property p_idle;
		!acc |-> prdata == 32'h0 && !pslverr;
	endproperty
	a_idle: assert property (p_idle) else $error("bus outputs outside access");
	// ==========================================
	// Homing status
	property p_tr;
		homing_busy |-> !target_reached;
	endproperty
	a_tr: assert property (p_tr) else $error("target reached while busy");
	property p_alm;
		homing_incomplete_alarm |-> !motor_run && !homing_attained;
	endproperty
	a_alm: assert property (p_alm) else $error("alarm with motion");
	property p_att;
		$rose(homing_attained) |-> !motor_run && !$past(motor_run);
	endproperty
	a_att: assert property (p_att) else $error("attained while moving");
	property p_lat;
		home_latch |=> !home_latch;
	endproperty
	a_lat: assert property (p_lat) else $error("home latch too long");
endmodule
bind hs_sequencer hs_sequencer_assertions u_chk (.pclk, .presetn, .psel, .penable, .paddr,
	.prdata, .pready, .pslverr, .motor_run, .home_latch, .homing_attained,
	.target_reached, .homing_incomplete_alarm, .homing_busy);
`default_nettype wire

// file: verif/tb_top.sv
// Testbench: homing sequencer scenarios over APB
`default_nettype none
module tb_top
	import hs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, e, servo_on = 1, load = 0;
	logic signed [15:0] load_pos = 16'sh0000, pos;
	logic index_pulse_in, prox_dog_in, fwd_stroke_end_in, rev_stroke_end_in;
	logic motor_stopped, motor_run, motor_fwd, motor_creep, home_latch, homing_attained;
	logic target_reached, homing_incomplete_alarm, homing_busy, irq;
	int error_cnt = 0, checks_done = 0, lats = 0;
	wire logic [3:0] flg = {!homing_busy, homing_incomplete_alarm, homing_attained, homing_busy};
	logic [15:0] tbl [6] = '{16'h0701, 16'h0B00, 16'h0730, 16'h0711, 16'h1230, 16'h1100};
	// Clock at 100 MHz
	always #5 pclk = !pclk;
	// Count home latch pulses mid-cycle, clear of the edge race
	always @(negedge pclk)
		if (home_latch === 1'b1)
			lats++;
	hs_sequencer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .index_pulse_in, .prox_dog_in, .fwd_stroke_end_in,
		.rev_stroke_end_in, .servo_on, .motor_stopped, .motor_run, .motor_fwd, .motor_creep,
		.home_latch, .homing_attained, .target_reached, .homing_incomplete_alarm,
		.homing_busy, .irq);
	hs_axis_model axis (.pclk, .presetn, .motor_run, .motor_fwd, .motor_creep, .load,
		.load_pos, .index_pulse_in, .prox_dog_in, .fwd_stroke_end_in, .rev_stroke_end_in,
		.motor_stopped, .pos);
	// ==========================================
	// Shared tasks
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		checks_done++;
		if (g !== x) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wt(input int k);
		for (int i = 0; i < 3000 && flg[k] !== 1'b1; i++)
			@(posedge pclk);
		chk(32'(flg[k]), 32'h1);
	endtask
	task automatic place(input logic signed [15:0] p, input logic s);
		load_pos <= p;
		servo_on <= s;
		load <= 1'b1;
		@(posedge pclk);
		load <= 1'b0;
	endtask
	task automatic go(input logic [7:0] m, input logic [3:0] c);
		apb(1'b1, HS_OFF_METHOD, {24'h0, m});
		apb(1'b1, HS_OFF_CTRL, {28'h0, c});
		apb(1'b1, HS_OFF_CTRL, {27'h0, 1'b1, c});
	endtask
	// ==========================================
	// Scenarios
	task automatic t_regs;
		apb(1'b0, HS_OFF_CTRL, 32'h0);
		chk(q, 32'h0);
		apb(1'b0, HS_OFF_METHOD, 32'h0);
		chk(q, 32'h0);
		apb(1'b0, HS_OFF_STATUS, 32'h0);
		chk(32'(q[HS_ST_TARGET]), 32'h1);
		apb(1'b0, 8'h14, 32'h0);
		chk({q[30:0], e}, 32'h1);
		$display("register test done");
	endtask
	task automatic t_cur;
		for (int k = 0; k < 2; k++) begin
			place(16'sh0000, 1'b0);
			lats = 0;
			apb(1'b1, HS_OFF_IRQ_MASK, 32'(1 - k));
			go(k ? 8'h25 : 8'h23, 4'h0);
			wt(1);
			repeat (2) @(posedge pclk);
			chk(32'({motor_run, 4'(lats)}), 32'h1);
			apb(1'b0, HS_OFF_IRQ_STAT, 32'h0);
			chk({q[30:0], irq}, {31'h1, 1'(1 - k)});
			apb(1'b1, HS_OFF_IRQ_STAT, 32'h1);
			apb(1'b0, HS_OFF_IRQ_STAT, 32'h0);
			chk({q[30:0], irq}, 32'h0);
		end
		$display("current position test done");
	endtask
	task automatic t_idx;
		place(16'sh0000, 1'b1);
		lats = 0;
		go(8'h22, 4'h0);
		wt(0);
		chk(32'({motor_run, motor_fwd, motor_creep}), 32'h7);
		wt(1);
		chk(32'({4'(lats), target_reached}), 32'h3);
		chk(32'(pos > 16'sd7 && pos < 16'sd16), 32'h1);
		$display("index test done");
	endtask
	task automatic t_dog;
		place(16'sd48, 1'b1);
		go(8'hFF, 4'h0);
		wt(0);
		chk(32'({motor_run, motor_fwd}), 32'h2);
		wt(1);
		place(16'sh0000, 1'b1);
		go(8'h13, 4'h0);
		wt(0);
		wt(1);
		chk(32'(pos < 16'sd52), 32'h1);
		$display("dog test done");
	endtask
	task automatic t_dir;
		for (int k = 0; k < 6; k++) begin
			place(16'sh0000, 1'b1);
			go(tbl[k][15:8], tbl[k][7:4]);
			wt(0);
			chk(32'(motor_fwd), 32'(tbl[k][0]));
			apb(1'b1, HS_OFF_CTRL, 32'h0);
			wt(3);
		end
		$display("direction test done");
	endtask
	task automatic t_end;
		place(-16'sd95, 1'b1);
		go(8'h21, 4'h0);
		wt(0);
		wt(2);
		apb(1'b0, HS_OFF_IRQ_STAT, 32'h0);
		chk(32'(q[HS_IRQ_ALARM]), 32'h1);
		chk(32'({motor_run, homing_attained}), 32'h0);
		$display("stroke end test done");
	endtask
	task automatic t_rev;
		place(16'sd60, 1'b1);
		lats = 0;
		go(8'h07, 4'h0);
		for (int i = 0; i < 3000 && !(motor_run === 1'b1 && motor_fwd === 1'b0); i++)
			@(posedge pclk);
		chk(32'({motor_run, motor_fwd, pos >= 16'sd100}), 32'h5);
		wt(1);
		chk(32'({4'(lats), pos > 16'sd54 && pos < 16'sd64}), 32'h3);
		$display("stroke reversal test done");
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Main sequence after reset
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs;
		t_cur;
		t_idx;
		t_dog;
		t_dir;
		t_rev;
		t_end;
		conclude;
	end
	// Watchdog
	initial begin
		#200us;
		error_cnt++;
		conclude;
	end
endmodule
`default_nettype wire
